// ===== card_dma_pkg.sv
// shared constants and types of the card host descriptor engine
package card_dma_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_FIFO_THRESHOLD_CONFIG = 8'h4C;
  localparam logic [7:0] OFF_BMOD   = 8'h80;
  localparam logic [7:0] OFF_PLDM   = 8'h84;
  localparam logic [7:0] OFF_LIST_BASE_ADDRESS = 8'h88;
  localparam logic [7:0] OFF_STS    = 8'h8C;
  localparam logic [7:0] OFF_INTEN  = 8'h90;
  localparam logic [7:0] OFF_CURDSC = 8'h94;
  localparam logic [7:0] OFF_CURBUF = 8'h98;
  // reset values
  localparam logic [31:0] RST_FIFO_THRESHOLD_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_BMOD   = 32'h0000_0000;
  localparam logic [31:0] RST_LIST_BASE_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_INTEN  = 32'h0000_0000;
  // bus mode fields
  localparam int BMOD_SWR = 0;
  localparam int BMOD_EN  = 7;
  // fifo threshold fields
  localparam int WM_W    = 12;
  localparam int TXWM_LO = 0;
  localparam int RXWM_LO = 16;
  // status and enable bit positions
  localparam int BIT_TI  = 0;
  localparam int BIT_RI  = 1;
  localparam int BIT_FBE = 2;
  localparam int BIT_DU  = 4;
  localparam int BIT_CES = 5;
  localparam int BIT_NIS = 8;
  localparam int BIT_AIS = 9;
  localparam logic [9:0] NORMAL_MASK = 10'h003;
  localparam logic [9:0] ABN_MASK    = 10'h034;
  // descriptor word zero and one fields
  localparam int D0_OWN = 31;
  localparam int D0_ER  = 5;
  localparam int D0_CH  = 4;
  localparam int D0_LD  = 2;
  localparam int D0_DIC = 1;
  localparam int BS_MSB = 12;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [12:0] BURST_BYTES = 13'h0010;
  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_BUSY   = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR4  = 3'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_DFETCH, S_CHECK, S_SUSP, S_WAITCMD, S_WAITREQ, S_XFER, S_WBACK
  } state_t;
endpackage

// ===== card_dma_fifo.sv
// small synchronous fifo between the bus master and the card data port
`timescale 1ns/1ps
`default_nettype none
module card_dma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_t;

  fifo_t s_r;
  fifo_t s_nxt;
  logic  push;
  logic  pop;

  assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data  = s_r.mem[s_r.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== card_host_descriptor_dma.sv
// descriptor chained dma engine of the card host controller
`timescale 1ns/1ps
`default_nettype none
// Operation
// - unowned descriptor suspends, flags descriptor unavailable
// - any poll demand write resumes suspended engine
// - wait clean command done before moving data
// - transmit moves only on watermark dma request
// - receive moves only on watermark dma request
// - bursts for data, singles for trailing words
// - transmit memory to fifo, receive fifo to memory
// - fetch next descriptor after every buffer, last flag included
// - transmit done sets status when enabled, clears ownership
// - receive done sets status bit one when enabled
// - status holds events, enable matches each
// - normal summary bit8, abnormal summary bit9
// - writing one clears status bit
// - summary clears when enabled group clears
// - interrupt drops only with both summaries clear
// - repeated events are not queued
// - concurrent events raise one interrupt
// - poll 0x84, base 0x88, status 0x8C
// - end of ring returns to list base
// - chained flag takes word three as next
// - no completion flag suppresses done status
module card_host_descriptor_dma
  import card_dma_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // bus master port
  output logic      [1:0]  o_htrans,
  output logic      [31:0] o_haddr,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [2:0]  o_hburst,
  output logic      [31:0] o_hwdata,
  input  wire logic [31:0] i_hrdata,
  input  wire logic        i_hready,
  input  wire logic        i_hresp,
  // card interface unit
  input  wire logic        i_command_done,
  input  wire logic        i_command_error,
  input  wire logic        i_dma_request,
  input  wire logic        i_card_write,
  output logic [WM_W-1:0]  o_transmit_watermark,
  output logic [WM_W-1:0]  o_receive_watermark,
  output logic      [31:0] o_tx_data,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  input  wire logic [31:0] i_rx_data,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  output logic             o_intr
);
  typedef struct packed {
    state_t      st;
    logic [31:0] bmod;
    logic [31:0] fifo_threshold_config;
    logic [31:0] list_base_address;
    logic [31:0] inten;
    logic [31:0] dsc;
    logic [31:0] bufp;
    logic [31:0] d0;
    logic [31:0] d3;
    logic [31:0] nxa;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] prdata;
    logic [9:0]  sts;
    logic [12:0] left;
    logic [1:0]  widx;
    logic [2:0]  nbeat;
    logic [2:0]  hburst;
    logic [1:0]  htrans;
    logic        act;
    logic        dph;
    logic        seq;
    logic        hwrite;
    logic        kick;
    logic        cmd_ok;
    logic        pslverr;
    logic        intr;
  } eng_t;

  eng_t s_r;
  eng_t s_nxt;
  logic wr;
  logic pd;
  logic beat_done;
  logic can_issue;
  logic go;
  logic fifo_in_ready;

  function automatic eng_t rst_val();
    eng_t x;
    x        = '0;
    x.st     = S_IDLE;
    x.bmod   = RST_BMOD;
    x.fifo_threshold_config = RST_FIFO_THRESHOLD_CONFIG;
    x.list_base_address = RST_LIST_BASE_ADDRESS;
    x.inten  = RST_INTEN;
    x.dsc    = RST_LIST_BASE_ADDRESS;
    x.htrans = HTRANS_IDLE;
    return x;
  endfunction

  // set up a four word burst read of the descriptor at addr
  function automatic eng_t start_fetch(eng_t x, logic [31:0] addr);
    eng_t y;
    y        = x;
    y.st     = S_DFETCH;
    y.dsc    = addr;
    y.nxa    = addr;
    y.nbeat  = 3'd4;
    y.hburst = HBURST_INCR4;
    y.hwrite = 1'b0;
    y.seq    = 1'b0;
    y.widx   = 2'd0;
    return y;
  endfunction

  function automatic logic is_mapped(logic [7:0] a);
    return a == OFF_FIFO_THRESHOLD_CONFIG || a == OFF_BMOD || a == OFF_PLDM || a == OFF_LIST_BASE_ADDRESS
        || a == OFF_STS || a == OFF_INTEN || a == OFF_CURDSC || a == OFF_CURBUF;
  endfunction

  assign wr        = i_psel && i_penable && i_pwrite;
  assign pd        = wr && (i_paddr == OFF_PLDM);
  assign beat_done = s_r.dph && i_hready;
  assign can_issue = !s_r.act && !s_r.dph && (s_r.nbeat != 3'd0);
  // a beat goes out only when its data has somewhere to come from or go
  assign go = can_issue && (s_r.st == S_DFETCH || s_r.st == S_WBACK
           || (s_r.st == S_XFER && (s_r.hwrite ? i_rx_valid : fifo_in_ready)));
  assign o_rx_ready = go && (s_r.st == S_XFER) && s_r.hwrite;

  always_comb begin
    s_nxt = s_r;

    // register port: reads answer in the access phase from the setup capture
    if (i_psel && !i_penable) begin
      s_nxt.pslverr = !is_mapped(i_paddr);
      if (!i_pwrite) begin
        unique case (i_paddr)
          OFF_FIFO_THRESHOLD_CONFIG: s_nxt.prdata = s_r.fifo_threshold_config;
          OFF_BMOD:   s_nxt.prdata = s_r.bmod;
          OFF_LIST_BASE_ADDRESS: s_nxt.prdata = s_r.list_base_address;
          OFF_STS:    s_nxt.prdata = {22'h0, s_r.sts};
          OFF_INTEN:  s_nxt.prdata = s_r.inten;
          OFF_CURDSC: s_nxt.prdata = s_r.dsc;
          OFF_CURBUF: s_nxt.prdata = s_r.bufp;
          default:    s_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr) begin
      unique case (i_paddr)
        OFF_FIFO_THRESHOLD_CONFIG: s_nxt.fifo_threshold_config = i_pwdata;
        OFF_BMOD: begin
          s_nxt.bmod = i_pwdata;
          s_nxt.bmod[BMOD_SWR] = 1'b0;
        end
        OFF_LIST_BASE_ADDRESS: begin
          s_nxt.list_base_address = i_pwdata;
          s_nxt.kick   = 1'b1;
          if (s_r.st == S_IDLE) begin
            s_nxt.dsc = i_pwdata;
          end
        end
        OFF_STS:   s_nxt.sts = s_r.sts & ~i_pwdata[9:0];
        OFF_INTEN: s_nxt.inten = i_pwdata;
        default: ;
      endcase
    end

    // address phase taken: hold the bus in busy between beats of a burst
    if (s_r.act && i_hready) begin
      s_nxt.act = 1'b0;
      s_nxt.dph = 1'b1;
      s_nxt.htrans = (s_r.nbeat != 3'd0 && s_r.hburst == HBURST_INCR4) ?
                     HTRANS_BUSY : HTRANS_IDLE;
    end
    if (beat_done) begin
      s_nxt.dph = 1'b0;
    end
    if (go) begin
      s_nxt.act    = 1'b1;
      s_nxt.htrans = (s_r.seq && s_r.hburst == HBURST_INCR4) ?
                     HTRANS_SEQ : HTRANS_NONSEQ;
      s_nxt.haddr  = s_r.nxa;
      s_nxt.nxa    = s_r.nxa + 32'd4;
      s_nxt.nbeat  = s_r.nbeat - 3'd1;
      s_nxt.seq    = 1'b1;
      if (s_r.st == S_XFER) begin
        s_nxt.hwdata = i_rx_data;
      end else begin
        s_nxt.hwdata = s_r.d0;
        s_nxt.hwdata[D0_OWN] = 1'b0;
      end
    end

    unique case (s_r.st)
      S_IDLE: begin
        if (s_r.bmod[BMOD_EN] && s_r.kick) begin
          s_nxt = start_fetch(s_nxt, s_nxt.dsc);
          s_nxt.kick = 1'b0;
        end
      end
      S_DFETCH: begin
        if (beat_done) begin
          unique case (s_r.widx)
            2'd0: s_nxt.d0 = i_hrdata;
            2'd1: s_nxt.left = i_hrdata[BS_MSB:0];
            2'd2: s_nxt.bufp = i_hrdata;
            2'd3: s_nxt.d3 = i_hrdata;
          endcase
          s_nxt.widx = s_r.widx + 2'd1;
          if (s_r.widx == 2'd3) begin
            s_nxt.st = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        if (!s_r.d0[D0_OWN]) begin
          s_nxt.st = S_SUSP;
          s_nxt.sts[BIT_DU] = 1'b1;
        end else begin
          s_nxt.st = S_WAITCMD;
        end
      end
      S_SUSP: begin
        if (pd) begin
          s_nxt = start_fetch(s_nxt, s_r.dsc);
        end
      end
      S_WAITCMD: begin
        if (s_r.cmd_ok) begin
          s_nxt.st = S_WAITREQ;
        end
      end
      S_WAITREQ: begin
        if (s_r.left == 13'd0) begin
          s_nxt.st     = S_WBACK;
          s_nxt.nxa    = s_r.dsc;
          s_nxt.nbeat  = 3'd1;
          s_nxt.hburst = HBURST_SINGLE;
          s_nxt.hwrite = 1'b1;
          s_nxt.seq    = 1'b0;
        end else if (i_dma_request) begin
          s_nxt.st  = S_XFER;
          s_nxt.nxa = s_r.bufp;
          s_nxt.seq = 1'b0;
          s_nxt.hwrite = !i_card_write;
          if (s_r.left >= BURST_BYTES) begin
            s_nxt.nbeat  = 3'd4;
            s_nxt.hburst = HBURST_INCR4;
          end else begin
            s_nxt.nbeat  = s_r.left[4:2];
            s_nxt.hburst = HBURST_SINGLE;
          end
        end
      end
      S_XFER: begin
        if (beat_done) begin
          s_nxt.left = s_r.left - 13'd4;
          s_nxt.bufp = s_r.bufp + 32'd4;
          if (s_r.nbeat == 3'd0) begin
            s_nxt.st = S_WAITREQ;
          end
        end
      end
      S_WBACK: begin
        if (beat_done) begin
          if (s_r.d0[D0_LD]) begin
            s_nxt.cmd_ok = 1'b0;
          end
          if (s_r.d0[D0_ER]) begin
            s_nxt = start_fetch(s_nxt, s_r.list_base_address);
          end else if (s_r.d0[D0_CH]) begin
            s_nxt = start_fetch(s_nxt, s_r.d3);
          end else begin
            s_nxt = start_fetch(s_nxt, s_r.dsc + DESC_BYTES);
          end
          if (!s_r.bmod[BMOD_EN]) begin
            s_nxt.st    = S_IDLE;
            s_nxt.nbeat = 3'd0;
            s_nxt.kick  = 1'b1;
          end
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase

    // bus error ends the operation and reports abnormally
    if (beat_done && i_hresp) begin
      s_nxt.sts[BIT_FBE] = 1'b1;
      s_nxt.st     = S_IDLE;
      s_nxt.nbeat  = 3'd0;
      s_nxt.act    = 1'b0;
      s_nxt.htrans = HTRANS_IDLE;
      s_nxt.kick   = 1'b0;
    end

    // completion of the last buffer; the set lands after any clear above
    if (s_r.st == S_WBACK && beat_done && !i_hresp && s_r.d0[D0_LD]
        && !s_r.d0[D0_DIC]) begin
      if (i_card_write) begin
        s_nxt.sts[BIT_TI] = s_r.sts[BIT_TI] | s_r.inten[BIT_TI]
                          | s_nxt.sts[BIT_TI];
      end else begin
        s_nxt.sts[BIT_RI] = s_r.inten[BIT_RI] | s_nxt.sts[BIT_RI];
      end
    end

    if (i_command_done) begin
      if (i_command_error) begin
        s_nxt.sts[BIT_CES] = 1'b1;
      end else begin
        s_nxt.cmd_ok = 1'b1;
      end
    end

    // summaries follow the enabled members of each group
    s_nxt.sts[BIT_NIS] = s_nxt.inten[BIT_NIS]
                       && |(s_nxt.sts & s_nxt.inten[9:0] & NORMAL_MASK);
    s_nxt.sts[BIT_AIS] = s_nxt.inten[BIT_AIS]
                       && |(s_nxt.sts & s_nxt.inten[9:0] & ABN_MASK);
    s_nxt.intr = s_nxt.sts[BIT_NIS] || s_nxt.sts[BIT_AIS];

    if (wr && i_paddr == OFF_BMOD && i_pwdata[BMOD_SWR]) begin
      s_nxt = rst_val();
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_r <= rst_val();
    end else begin
      s_r <= s_nxt;
    end
  end

  card_dma_fifo #(
    .WIDTH (32),
    .DEPTH (4)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (beat_done && !i_hresp && s_r.st == S_XFER && !s_r.hwrite),
    .i_in_data   (i_hrdata),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_data),
    .i_out_ready (i_tx_ready)
  );

  assign o_prdata  = s_r.prdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = s_r.pslverr;
  assign o_htrans  = s_r.htrans;
  assign o_haddr   = s_r.haddr;
  assign o_hwrite  = s_r.hwrite;
  assign o_hsize   = HSIZE_WORD;
  assign o_hburst  = s_r.hburst;
  assign o_hwdata  = s_r.hwdata;
  assign o_intr    = s_r.intr;
  assign o_transmit_watermark = s_r.fifo_threshold_config[TXWM_LO +: WM_W];
  assign o_receive_watermark  = s_r.fifo_threshold_config[RXWM_LO +: WM_W];
endmodule
`default_nettype wire

// ===== card_dma_properties.sv
// port level properties of the descriptor dma engine
`timescale 1ns/1ps
`default_nettype none
module card_dma_properties
  import card_dma_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_reset_n,
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic [7:0]      i_paddr,
  input wire logic [31:0]     i_pwdata,
  input wire logic [31:0]     o_prdata,
  input wire logic            o_pslverr,
  input wire logic [1:0]      o_htrans,
  input wire logic [31:0]     o_haddr,
  input wire logic            o_hwrite,
  input wire logic            i_hready,
  input wire logic            i_command_done,
  input wire logic            i_command_error,
  input wire logic            i_dma_request,
  input wire logic            i_card_write,
  input wire logic [WM_W-1:0] o_transmit_watermark,
  input wire logic [WM_W-1:0] o_receive_watermark,
  input wire logic            o_tx_valid,
  input wire logic            o_rx_ready,
  input wire logic            o_intr
);
  logic acc;
  logic wr;
  logic mapped;
  logic cmd_ok_r;
  logic req_r;
  logic en_r;
  logic [31:0] last_a;
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign mapped = (i_paddr == OFF_FIFO_THRESHOLD_CONFIG) ||
                  (i_paddr >= OFF_BMOD && i_paddr <= OFF_CURBUF && i_paddr[1:0] == 2'h0);
  // sticky: clean command done, request and enable seen since reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmd_ok_r <= 1'b0;
      req_r <= 1'b0;
      en_r <= 1'b0;
      last_a <= 32'h0;
    end else begin
      if (o_htrans[1] && i_hready) begin
        last_a <= o_haddr;
      end
      cmd_ok_r <= cmd_ok_r || (i_command_done && !i_command_error);
      req_r <= req_r || i_dma_request;
      en_r <= en_r || (wr && i_paddr == OFF_BMOD && i_pwdata[BMOD_EN]);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_unmapped_err: assert property (acc && !mapped |-> o_pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && mapped |-> !o_pslverr)
    else $error("mapped access flagged");
  a_poll_reads_zero: assert property (acc && !i_pwrite && i_paddr == OFF_PLDM |-> o_prdata == 32'h0)
    else $error("poll register readable");
  a_watermark_load: assert property (wr && i_paddr == OFF_FIFO_THRESHOLD_CONFIG |=>
    o_transmit_watermark == $past(i_pwdata[11:0]) && o_receive_watermark == $past(i_pwdata[27:16]))
    else $error("watermark not loaded");
  a_fetch_enabled: assert property (o_htrans != HTRANS_IDLE |-> en_r)
    else $error("bus access while disabled");
  a_rx_after_cmd: assert property (o_rx_ready |->
    cmd_ok_r && req_r && o_hwrite && !i_card_write ##1 o_htrans[1])
    else $error("receive pop out of order");
  a_tx_after_cmd: assert property ($rose(o_tx_valid) |-> cmd_ok_r && req_r)
    else $error("transmit data before command done");
  a_beat_hold: assert property (o_htrans[1] && !i_hready |=> $stable(o_haddr) && $stable(o_htrans))
    else $error("address beat changed while stalled");
  a_burst_step: assert property (o_htrans == HTRANS_SEQ |-> o_haddr == last_a + 32'h4)
    else $error("burst address step wrong");
  a_intr_drop: assert property ($fell(o_intr) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("interrupt dropped without status write");
endmodule
bind card_host_descriptor_dma card_dma_properties u_props (.*);
`default_nettype wire

// ===== card_dma_partner.sv
// host memory slave and card data port model
`timescale 1ns/1ps
`default_nettype none
module card_dma_partner (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_rnd,
  input  wire logic [1:0]  i_htrans,
  input  wire logic [31:0] i_haddr,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hready,
  output logic             o_hresp,
  input  wire logic [31:0] i_tx_data,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  output logic      [31:0] o_rx_data,
  output logic             o_rx_valid,
  input  wire logic        i_rx_ready
);
  logic [31:0] mem [0:255];
  logic [31:0] txq [$];
  logic        pend;
  logic        pw;
  logic [31:0] pa;
  logic [31:0] rxn;
  initial begin
    pend = 1'b0;
    rxn = 32'h0;
    o_hrdata = 32'h0;
    o_hready = 1'b1;
    o_hresp = 1'b0;
    o_tx_ready = 1'b1;
    o_rx_valid = 1'b1;
    o_rx_data = 32'hA000_0000;
  end
  // wait states only in data phases; idle read bus toggles
  always @(negedge i_clk) begin
    o_hready <= !(pend && i_slow && i_rnd[0]);
    o_tx_ready <= !(i_slow && i_rnd[1]);
    o_hrdata <= (pend && !pw) ? mem[pa[9:2]] : ~o_hrdata;
    o_rx_data <= 32'hA000_0000 + rxn;
  end
  always @(posedge i_clk) begin
    if (pend && o_hready && pw) begin
      mem[pa[9:2]] <= i_hwdata;
    end
    if (o_hready) begin
      pend <= i_htrans[1];
      pa <= i_haddr;
      pw <= i_hwrite;
    end
    if (i_tx_valid && o_tx_ready) begin
      txq.push_back(i_tx_data);
    end
    if (i_rx_ready && o_rx_valid) begin
      rxn <= rxn + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the descriptor dma engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import card_dma_pkg::*;
  logic i_clk, i_reset_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_hwrite;
  logic i_hready, i_hresp, i_command_done, i_command_error, i_dma_request, i_card_write;
  logic o_tx_valid, i_tx_ready, i_rx_valid, o_rx_ready, o_intr, slow;
  logic [7:0]      i_paddr;
  logic [1:0]      o_htrans;
  logic [2:0]      o_hsize, o_hburst;
  logic [31:0]     i_pwdata, o_prdata, o_haddr, o_hwdata, i_hrdata, o_tx_data, i_rx_data;
  logic [31:0]     rnd, wm, w;
  logic [WM_W-1:0] o_transmit_watermark, o_receive_watermark;
  logic [31:0]     exp_tx [$];
  logic [7:0]      offs [0:6] = '{OFF_FIFO_THRESHOLD_CONFIG, OFF_BMOD, OFF_PLDM, OFF_LIST_BASE_ADDRESS, OFF_STS,
                                  OFF_INTEN, OFF_CURDSC};
  int              seed, n_errors, compares, cycles, k;
  card_host_descriptor_dma dut (.*);
  card_dma_partner u_mem (.i_clk(i_clk), .i_slow(slow), .i_rnd(rnd), .i_htrans(o_htrans),
    .i_haddr(o_haddr), .i_hwrite(o_hwrite), .i_hwdata(o_hwdata), .o_hrdata(i_hrdata),
    .o_hready(i_hready), .o_hresp(i_hresp), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
    .o_tx_ready(i_tx_ready), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid),
    .i_rx_ready(o_rx_ready));
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) rnd <= $random(seed);
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(negedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 1'b0, wr_en, a, d};
    @(negedge i_clk);
    i_penable = 1'b1;
    @(posedge i_clk);
    q = o_prdata;
    e = o_pslverr;
    @(negedge i_clk);
    {i_psel, i_penable} = 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    acc(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    acc(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, err}, "slave error");
  endtask
  // poll status until expected, then compare
  task automatic wait_sts(input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    for (int n = 0; n < 300; n++) begin
      acc(1'b0, OFF_STS, 32'h0, q, e);
      if (q === exp) break;
    end
    chk(q, exp, "status");
  endtask
  task automatic desc(input logic [9:0] a, input logic [31:0] w0, w1, w2, w3);
    {u_mem.mem[a[9:2]], u_mem.mem[a[9:2]+1], u_mem.mem[a[9:2]+2], u_mem.mem[a[9:2]+3]} =
      {w0, w1, w2, w3};
  endtask
  task automatic cmd_done();
    @(negedge i_clk);
    i_command_done = 1'b1;
    @(negedge i_clk);
    i_command_done = 1'b0;
  endtask
  initial begin
    seed = 32'hc832;
    {i_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_command_done, i_command_error, i_dma_request, slow} = '0;
    i_card_write = 1'b1;
    {n_errors, compares, cycles} = '0;
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    foreach (offs[j]) rd(offs[j], 32'h0, 1'b0);
    rd(8'h00, 32'h0, 1'b1);
    rd(8'h9C, 32'h0, 1'b1);
    wm = $random(seed) & 32'h0FFF_0FFF;
    wr(OFF_FIFO_THRESHOLD_CONFIG, wm);
    chk({20'h0, o_transmit_watermark}, {20'h0, wm[11:0]}, "tx mark");
    chk({20'h0, o_receive_watermark}, {20'h0, wm[27:16]}, "rx mark");
    slow = 1'b1;
    wr(OFF_BMOD, 32'h0000_0080);
    wr(OFF_INTEN, 32'h0000_0337);
    desc(10'h040, 32'h8000_0014, 32'd24, 32'h100, 32'h080);
    desc(10'h080, 32'h0, 32'h0, 32'h0, 32'h0);
    for (k = 0; k < 6; k++) begin
      w = $random(seed);
      u_mem.mem[64+k] = w;
      exp_tx.push_back(w);
    end
    wr(OFF_LIST_BASE_ADDRESS, 32'h40);
    rd(OFF_LIST_BASE_ADDRESS, 32'h40, 1'b0);
    cmd_done();
    repeat (60) @(negedge i_clk);
    chk(u_mem.txq.size(), 0, "tx before request");
    i_dma_request = 1'b1;
    wait_sts(32'h0000_0311);
    chk(u_mem.txq.size(), 6, "tx count");
    foreach (exp_tx[j]) chk(u_mem.txq[j], exp_tx[j], "tx word");
    chk(u_mem.mem[16], 32'h0000_0014, "tx writeback");
    chk({31'h0, o_intr}, 32'h1, "intr raised");
    wr(OFF_STS, 32'h0);
    rd(OFF_STS, 32'h0000_0311, 1'b0);
    wr(OFF_STS, 32'h0000_0001);
    rd(OFF_STS, 32'h0000_0210, 1'b0);
    chk({31'h0, o_intr}, 32'h1, "intr held");
    wr(OFF_STS, 32'h0000_0010);
    rd(OFF_STS, 32'h0, 1'b0);
    chk({31'h0, o_intr}, 32'h0, "intr dropped");
    // two chained receive buffers, ring back to base
    i_card_write = 1'b0;
    desc(10'h080, 32'h8000_0010, 32'd16, 32'h200, 32'h0C0);
    desc(10'h0C0, 32'h8000_0024, 32'd8, 32'h280, 32'h0);
    wr(OFF_PLDM, $random(seed));
    cmd_done();
    wait_sts(32'h0000_0312);
    for (k = 0; k < 6; k++) begin
      chk(u_mem.mem[(k < 4) ? 128 + k : 156 + k], 32'hA000_0000 + k, "rx word");
    end
    chk(u_mem.mem[32], 32'h0000_0010, "rx writeback a");
    chk(u_mem.mem[48], 32'h0000_0024, "rx writeback b");
    wr(OFF_STS, 32'h0000_0312);
    // single word buffer that suppresses the done status
    desc(10'h040, 32'h8000_0026, 32'd4, 32'h300, 32'h0);
    wr(OFF_PLDM, 32'h0);
    cmd_done();
    wait_sts(32'h0000_0210);
    chk(u_mem.mem[192], 32'hA000_0006, "rx single");
    give_verdict();
  end
endmodule
`default_nettype wire
